// ==== rtl/sdcl_pkg.sv ====
// package: constants for the serial converter command latch
// assumes: shared by the latch top, its checker and its testbench
package sdcl_pkg;

    // command word layout
    localparam int unsigned WORD_BITS  = 16;
    localparam int unsigned CODE_W     = 12;
    localparam int unsigned CNT_W      = 5;
    localparam int unsigned BIT_IGNORE = 15;
    localparam int unsigned BIT_BUF    = 14;
    localparam int unsigned BIT_GAIN_N = 13;
    localparam int unsigned BIT_ACTIVE = 12;
    localparam int unsigned CODE_MSB   = 11;

    // clock counting on the link
    localparam logic [CNT_W-1:0] CNT_ZERO   = 5'h00;
    localparam logic [CNT_W-1:0] CNT_ONE    = 5'h01;
    localparam logic [CNT_W-1:0] FRAME_CLKS = 5'h10;
    localparam logic [CNT_W-1:0] LAST_CLK   = 5'h0F;

    // reset values of the settings
    localparam logic              RST_BUF    = 1'b0;
    localparam logic              RST_GAIN_N = 1'b0;
    localparam logic              RST_ACTIVE = 1'b0;
    localparam logic [CODE_W-1:0] RST_CODE   = 12'h000;
    localparam logic [WORD_BITS-1:0] RST_WORD = 16'h0000;

    // synchroniser reset pattern: cs high, strobe high, toggle low
    localparam logic [2:0] SYNC_RST = 3'h6;

    // frame tracking on the system clock
    typedef enum logic {
        FR_IDLE,
        FR_BUSY
    } sdcl_frame_t;

endpackage

// ==== rtl/sdcl_sync.sv ====
// module: two-flop level synchroniser, one bit per lane
// assumes: inputs are levels from another domain or from pins
`timescale 1ns/1ps
`default_nettype none

module sdcl_sync #(
    parameter int unsigned       WIDTH   = 1,
    parameter logic [WIDTH-1:0]  RST_VAL = '0
) (
    // clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rst_b,
    // asynchronous levels in, synchronised levels out
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] sync_reg;
    logic [WIDTH-1:0] sync_next;

    // first stage is read only by the second
    always_comb begin
        meta_next = async_in;
        sync_next = meta_reg;
        if (!rst_b) begin
            meta_next = RST_VAL;
            sync_next = RST_VAL;
        end
    end

    always_ff @(posedge clk_sys) begin
        meta_reg <= meta_next;
        sync_reg <= sync_next;
    end

    assign sync_out = sync_reg;

endmodule // sdcl_sync

`default_nettype wire

// ==== rtl/sdcl_top.sv ====
// module: serial command latch of a single-channel voltage converter
// assumes: spi host (mode 0,0 or 1,1) on the link clock, latch strobe from a pin,
// system clock unrelated to the link clock
//
// Notes on behaviour
// RULE1: sample data on every rising link clock edge while chip select is low
// RULE2: link is receive only, nothing can be read back
// RULE3: host keeps chip select low for all clocks of a command
// RULE4: commands are 16 bits, 4 configuration bits then 12 code bits
// RULE5: chip select falls, then configuration bits, then data bits arrive
// RULE6: clocks after the sixteenth are ignored and never change the word
// RULE7: word loads on chip select rise only after sixteen clocks, else aborted
// RULE8: no data shifts while chip select is high
// RULE9: low latch strobe copies the input register into the output register
// RULE10: gain bit one gives unity gain, zero gives double gain, default double
// RULE11: buffer bit zero bypasses reference buffer, default unbuffered
// RULE12: after reset output is shut down until valid write and strobe low
// RULE13: reset holds the block, leaving it needs a following write
// RULE14: receiver keeps working during shutdown
// RULE15: shutdown lasts until a command with the active bit set is latched
// RULE16: straight binary code of 8, 10 or 12 bits by parameter
// RULE17: a command with bit 15 set is discarded
// RULE18: short codes sit at the top of the field, low bits ignored
// RULE19: bit 12 at one means active, at zero shutdown with output off
// RULE20: strobe held low updates output as soon as a full frame ends
// RULE21: command shifts most significant bit first
// RULE22: clock counter cleared at frame start, judged at chip select rise
`timescale 1ns/1ps
`default_nettype none

module sdcl_top
    import sdcl_pkg::*;
#(
    parameter int unsigned RES = CODE_W
) (
    // system clock and reset
    input  wire logic           clk_sys,
    input  wire logic           rst_b,
    // serial link, receive only
    input  wire logic           spi_sclk,
    input  wire logic           spi_cs_n,
    input  wire logic           spi_mosi,
    // output latch strobe pin
    input  wire logic           output_latch_strobe_n,
    // settings applied to the converter
    output logic [RES-1:0]      converter_code,
    output logic                gain_select_n,
    output logic                ref_buffered,
    output logic                active_not_shutdown,
    // settings waiting in the input register
    output logic [RES-1:0]      staged_code,
    output logic                staged_gain_select_n,
    output logic                staged_ref_buffered,
    output logic                staged_active,
    // frame outcome pulses
    output logic                frame_loaded,
    output logic                frame_ignored,
    output logic                frame_aborted
);

    // ------------------------------------------------------------------
    // link clock domain
    // ------------------------------------------------------------------

    logic                 frame_clr;
    logic [CNT_W-1:0]     bit_cnt_reg;
    logic [CNT_W-1:0]     bit_cnt_next;
    logic [WORD_BITS-2:0] shift_reg;
    logic [WORD_BITS-2:0] shift_next;
    logic [WORD_BITS-1:0] word_hold_reg;
    logic [WORD_BITS-1:0] word_hold_next;
    logic                 word_tgl_reg;
    logic                 word_tgl_next;

    // chip select high holds counter and shifter clear
    assign frame_clr = spi_cs_n | ~rst_b; // [RULE8] [RULE22] [RULE14]

    always_comb begin
        bit_cnt_next   = bit_cnt_reg;
        shift_next     = shift_reg;
        word_hold_next = word_hold_reg;
        word_tgl_next  = word_tgl_reg;
        if (bit_cnt_reg < FRAME_CLKS) begin // [RULE6]
            shift_next   = {shift_reg[WORD_BITS-3:0], spi_mosi}; // [RULE1] [RULE21] [RULE5]
            bit_cnt_next = bit_cnt_reg + CNT_ONE; // [RULE22]
            if (bit_cnt_reg == LAST_CLK) begin
                word_hold_next = {shift_reg, spi_mosi}; // [RULE4]
                word_tgl_next  = ~word_tgl_reg;
            end
        end
    end

    // counter and shifter, cleared by the frame's own chip select
    always_ff @(posedge spi_sclk or posedge frame_clr) begin
        if (frame_clr) begin
            bit_cnt_reg <= CNT_ZERO;
            shift_reg   <= RST_WORD[WORD_BITS-2:0];
        end else begin
            bit_cnt_reg <= bit_cnt_next;
            shift_reg   <= shift_next;
        end
    end

    // completed word and its event toggle
    always_ff @(posedge spi_sclk or negedge rst_b) begin
        if (!rst_b) begin
            word_hold_reg <= RST_WORD;
            word_tgl_reg  <= 1'b0;
        end else begin
            word_hold_reg <= word_hold_next;
            word_tgl_reg  <= word_tgl_next;
        end
    end

    // ------------------------------------------------------------------
    // crossing into the system clock domain
    // ------------------------------------------------------------------

    logic [2:0] sync_in;
    logic [2:0] sync_q;
    logic       cs_n_s;
    logic       strobe_n_s;
    logic       tgl_s;

    assign sync_in = {spi_cs_n, output_latch_strobe_n, word_tgl_reg};

    sdcl_sync #(
        .WIDTH   (3),
        .RST_VAL (SYNC_RST)
    ) u_sync (
        .clk_sys  (clk_sys),
        .rst_b    (rst_b),
        .async_in (sync_in),
        .sync_out (sync_q)
    );

    assign cs_n_s     = sync_q[2];
    assign strobe_n_s = sync_q[1];
    assign tgl_s      = sync_q[0];

    // ------------------------------------------------------------------
    // system clock domain: frame tracking
    // ------------------------------------------------------------------

    sdcl_frame_t state_reg;
    sdcl_frame_t state_next;
    logic        cs_late_reg;
    logic        cs_late_next;
    logic        tgl_seen_reg;
    logic        tgl_seen_next;
    logic        frame_end;
    logic        word_new;

    // one extra stage so the toggle has settled before the edge is judged
    always_comb begin
        cs_late_next = cs_n_s;
        if (!rst_b) begin
            cs_late_next = 1'b1;
        end
    end

    always_comb begin
        state_next = state_reg;
        frame_end  = 1'b0;
        case (state_reg)
            FR_IDLE: begin
                if (!cs_late_reg) begin
                    state_next = FR_BUSY;
                end
            end
            FR_BUSY: begin
                if (cs_late_reg) begin
                    state_next = FR_IDLE;
                    frame_end  = 1'b1; // [RULE7]
                end
            end
            default: begin
                state_next = FR_IDLE;
            end
        endcase
        if (!rst_b) begin
            state_next = FR_IDLE;
            frame_end  = 1'b0;
        end
    end

    // sixteen clocks seen in this frame
    assign word_new = (tgl_s != tgl_seen_reg); // [RULE7] [RULE22]

    always_comb begin
        tgl_seen_next = tgl_seen_reg;
        if (frame_end && word_new) begin
            tgl_seen_next = tgl_s;
        end
        if (!rst_b) begin
            tgl_seen_next = tgl_s;
        end
    end

    always_ff @(posedge clk_sys) begin
        state_reg    <= state_next;
        cs_late_reg  <= cs_late_next;
        tgl_seen_reg <= tgl_seen_next;
    end

    // ------------------------------------------------------------------
    // input register and frame outcome
    // ------------------------------------------------------------------

    logic [RES-1:0] in_code_reg;
    logic [RES-1:0] in_code_next;
    logic           in_gain_n_reg;
    logic           in_gain_n_next;
    logic           in_buf_reg;
    logic           in_buf_next;
    logic           in_active_reg;
    logic           in_active_next;
    logic           loaded_reg;
    logic           loaded_next;
    logic           ignored_reg;
    logic           ignored_next;
    logic           aborted_reg;
    logic           aborted_next;

    always_comb begin
        in_code_next   = in_code_reg;
        in_gain_n_next = in_gain_n_reg;
        in_buf_next    = in_buf_reg;
        in_active_next = in_active_reg;
        loaded_next    = 1'b0;
        ignored_next   = 1'b0;
        aborted_next   = 1'b0;
        if (frame_end) begin
            if (!word_new) begin
                aborted_next = 1'b1; // [RULE7]
            end else if (word_hold_reg[BIT_IGNORE]) begin
                ignored_next = 1'b1; // [RULE17]
            end else begin
                loaded_next    = 1'b1;
                in_code_next   = word_hold_reg[CODE_MSB -: RES]; // [RULE16] [RULE18]
                in_gain_n_next = word_hold_reg[BIT_GAIN_N]; // [RULE10]
                in_buf_next    = word_hold_reg[BIT_BUF]; // [RULE11]
                in_active_next = word_hold_reg[BIT_ACTIVE]; // [RULE19]
            end
        end
        if (!rst_b) begin
            in_code_next   = RST_CODE[CODE_MSB -: RES]; // [RULE13]
            in_gain_n_next = RST_GAIN_N;
            in_buf_next    = RST_BUF;
            in_active_next = RST_ACTIVE;
            loaded_next    = 1'b0;
            ignored_next   = 1'b0;
            aborted_next   = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        in_code_reg   <= in_code_next;
        in_gain_n_reg <= in_gain_n_next;
        in_buf_reg    <= in_buf_next;
        in_active_reg <= in_active_next;
        loaded_reg    <= loaded_next;
        ignored_reg   <= ignored_next;
        aborted_reg   <= aborted_next;
    end

    // ------------------------------------------------------------------
    // output register, level sensitive to the latch strobe
    // ------------------------------------------------------------------

    logic [RES-1:0] out_code_reg;
    logic [RES-1:0] out_code_next;
    logic           out_gain_n_reg;
    logic           out_gain_n_next;
    logic           out_buf_reg;
    logic           out_buf_next;
    logic           out_active_reg;
    logic           out_active_next;

    always_comb begin
        out_code_next   = out_code_reg;
        out_gain_n_next = out_gain_n_reg;
        out_buf_next    = out_buf_reg;
        out_active_next = out_active_reg;
        if (!strobe_n_s) begin
            out_code_next   = in_code_reg; // [RULE9] [RULE20]
            out_gain_n_next = in_gain_n_reg;
            out_buf_next    = in_buf_reg;
            out_active_next = in_active_reg; // [RULE15]
        end
        if (!rst_b) begin
            out_code_next   = RST_CODE[CODE_MSB -: RES];
            out_gain_n_next = RST_GAIN_N; // [RULE10]
            out_buf_next    = RST_BUF; // [RULE11]
            out_active_next = RST_ACTIVE; // [RULE12] [RULE13]
        end
    end

    always_ff @(posedge clk_sys) begin
        out_code_reg   <= out_code_next;
        out_gain_n_reg <= out_gain_n_next;
        out_buf_reg    <= out_buf_next;
        out_active_reg <= out_active_next;
    end

    // ------------------------------------------------------------------
    // outputs; no path leads back onto the link
    // ------------------------------------------------------------------

    assign converter_code       = out_code_reg; // [RULE2]
    assign gain_select_n        = out_gain_n_reg;
    assign ref_buffered         = out_buf_reg;
    assign active_not_shutdown  = out_active_reg; // [RULE19]
    assign staged_code          = in_code_reg;
    assign staged_gain_select_n = in_gain_n_reg;
    assign staged_ref_buffered  = in_buf_reg;
    assign staged_active        = in_active_reg;
    assign frame_loaded         = loaded_reg;
    assign frame_ignored        = ignored_reg;
    assign frame_aborted        = aborted_reg;

endmodule // sdcl_top

`default_nettype wire

// ==== verification/sdcl_host.sv ====
// model: spi host on the link, 15 ns link clock
// assumes: clock stands still outside frames, except for the stray clocks
`timescale 1ns/1ps
`default_nettype none

module sdcl_host (
    // link outputs
    output var logic spi_sclk,
    output var logic spi_cs_n,
    output var logic spi_mosi
);
    initial begin
        spi_sclk = 1'b0;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b1;
    end

    // n clocks of word w, msb first, idle level cpol
    task automatic send(input logic [15:0] w, input int n, input logic cpol);
        spi_sclk = cpol;
        #7.5 spi_cs_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            spi_sclk = 1'b0;
            spi_mosi = w[15 - (i % 16)];
            #7.5 spi_sclk = 1'b1;
            #7.5;
        end
        spi_sclk = cpol;
        #7.5 spi_cs_n = 1'b1;
        spi_mosi = ~spi_mosi;
    endtask

    // clocks with chip select high, data toggling
    task automatic stray(input int n);
        for (int i = 0; i < n; i++) begin
            spi_mosi = ~spi_mosi;
            #7.5 spi_sclk = 1'b1;
            #7.5 spi_sclk = 1'b0;
        end
    endtask
endmodule // sdcl_host

`default_nettype wire

// ==== verification/sdcl_top_chk.sv ====
// checker: port-level properties of the serial command latch
// assumes: bound to sdcl_top, one system clock domain
`timescale 1ns/1ps
`default_nettype none

module sdcl_top_chk
    import sdcl_pkg::*;
#(
    parameter int unsigned RES = CODE_W
) (
    // clock and reset
    input wire logic           clk_sys,
    input wire logic           rst_b,
    // link and strobe
    input wire logic           spi_sclk,
    input wire logic           spi_cs_n,
    input wire logic           spi_mosi,
    input wire logic           output_latch_strobe_n,
    // applied and staged settings
    input wire logic [RES-1:0] converter_code,
    input wire logic           gain_select_n,
    input wire logic           ref_buffered,
    input wire logic           active_not_shutdown,
    input wire logic [RES-1:0] staged_code,
    input wire logic           staged_gain_select_n,
    input wire logic           staged_ref_buffered,
    input wire logic           staged_active,
    // frame outcomes
    input wire logic           frame_loaded,
    input wire logic           frame_ignored,
    input wire logic           frame_aborted
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    wire [2:0] pulses = {frame_loaded, frame_ignored, frame_aborted};
    wire [RES+2:0] applied = {ref_buffered, gain_select_n, active_not_shutdown, converter_code};
    wire [RES+2:0] staged = {staged_ref_buffered, staged_gain_select_n, staged_active, staged_code};

    pulse_onehot_a: assert property ($onehot0(pulses))
        else $error("two frame outcomes together");
    pulse_single_a: assert property (|pulses |=> pulses == 3'h0)
        else $error("frame outcome longer than one cycle");
    staged_cause_a: assert property (!$stable(staged) |-> frame_loaded)
        else $error("input register changed without a load");
    frame_end_a: assert property (|pulses |-> spi_cs_n && $past(spi_cs_n, 3))
        else $error("frame outcome without chip select rise");
    cs_low_quiet_a: assert property (!spi_cs_n [*5] |-> pulses == 3'h0)
        else $error("frame outcome inside a frame");
    hold_high_a: assert property (output_latch_strobe_n [*5] |-> $stable(applied))
        else $error("output changed with strobe high");
    copy_low_a: assert property (!output_latch_strobe_n [*5] |-> applied == $past(staged))
        else $error("output does not follow input register");
    wake_cause_a: assert property ($rose(active_not_shutdown) |-> $past(staged_active))
        else $error("left shutdown without active bit");
    reset_clear_a: assert property (disable iff (1'b0) !rst_b |=> applied == '0 && staged == '0)
        else $error("settings not cleared by reset");

    cover property (frame_loaded && !output_latch_strobe_n);
    cover property (frame_aborted);
    cover property (frame_ignored);
    cover property ($rose(active_not_shutdown));
endmodule // sdcl_top_chk

bind sdcl_top sdcl_top_chk #(.RES(RES)) sdcl_top_chk_i (
    .clk_sys(clk_sys), .rst_b(rst_b), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi), .output_latch_strobe_n(output_latch_strobe_n),
    .converter_code(converter_code), .gain_select_n(gain_select_n),
    .ref_buffered(ref_buffered), .active_not_shutdown(active_not_shutdown),
    .staged_code(staged_code), .staged_gain_select_n(staged_gain_select_n),
    .staged_ref_buffered(staged_ref_buffered), .staged_active(staged_active),
    .frame_loaded(frame_loaded), .frame_ignored(frame_ignored),
    .frame_aborted(frame_aborted)
);

`default_nettype wire

// ==== verification/tb_sdcl_top.sv ====
// testbench: frames, strobe and reset of the command latch
// assumes: host model on the link, strobe driven here
`timescale 1ns/1ps
`default_nettype none

module tb_sdcl_top;
    import sdcl_pkg::*;

    logic              clk_sys;
    logic              rst_b = 1'b0;
    logic              output_latch_strobe_n = 1'b1;
    wire               sclk, cs_n, mosi;
    logic [CODE_W-1:0] code, s_code;
    logic              gain_n, ref_buf, active, s_gain_n, s_buf, s_active;
    logic              loaded, ignored, aborted;
    int                n_errors = 0;
    int                check_count = 0;

    wire [15:0] applied = {1'b0, ref_buf, gain_n, active, code};
    wire [15:0] staged = {1'b0, s_buf, s_gain_n, s_active, s_code};

    sdcl_host sdcl_host_i (.spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi));

    sdcl_top sdcl_top_i (
        .clk_sys(clk_sys), .rst_b(rst_b), .spi_sclk(sclk), .spi_cs_n(cs_n),
        .spi_mosi(mosi), .output_latch_strobe_n(output_latch_strobe_n),
        .converter_code(code), .gain_select_n(gain_n), .ref_buffered(ref_buf),
        .active_not_shutdown(active), .staged_code(s_code),
        .staged_gain_select_n(s_gain_n), .staged_ref_buffered(s_buf),
        .staged_active(s_active), .frame_loaded(loaded),
        .frame_ignored(ignored), .frame_aborted(aborted)
    );

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one frame, then a bounded window collecting outcome pulses
    task automatic frame(input logic [15:0] w, input int n, input logic cpol,
                         input logic [2:0] exp);
        logic [2:0] got;
        got = 3'h0;
        sdcl_host_i.send(w, n, cpol);
        for (int i = 0; i < 12; i++) begin
            @(negedge clk_sys);
            got |= {loaded, ignored, aborted};
        end
        chk({13'h0, got}, {13'h0, exp});
    endtask

    task automatic strobe(input logic lvl);
        @(negedge clk_sys);
        output_latch_strobe_n = lvl;
        repeat (4) @(negedge clk_sys);
    endtask

    task automatic complete_run;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        // link clocks inside reset clear the link-side flops
        sdcl_host_i.stray(2);
        repeat (16) @(negedge clk_sys);
        rst_b = 1'b1;
        @(negedge clk_sys);
        chk(applied, 16'h0000);
        chk(staged, 16'h0000);
        frame(16'h7ABC, 16, 1'b0, 3'h4);
        chk(staged, 16'h7ABC);
        chk(applied, 16'h0000);
        strobe(1'b0);
        chk(applied, 16'h7ABC);
        frame(16'h2123, 16, 1'b1, 3'h4);
        chk(applied, 16'h2123);
        frame(16'h1FFF, 16, 1'b0, 3'h4);
        chk(applied, 16'h1FFF);
        frame(16'h5A5A, 20, 1'b0, 3'h4);
        chk(staged, 16'h5A5A);
        strobe(1'b1);
        frame(16'h4321, 10, 1'b0, 3'h1);
        chk(staged, 16'h5A5A);
        frame(16'hF0F0, 16, 1'b1, 3'h2);
        chk(staged, 16'h5A5A);
        sdcl_host_i.stray(8);
        repeat (12) @(negedge clk_sys);
        chk(staged, 16'h5A5A);
        frame(16'h3456, 16, 1'b0, 3'h4);
        chk(staged, 16'h3456);
        chk(applied, 16'h5A5A);
        @(negedge clk_sys);
        rst_b = 1'b0;
        repeat (4) @(negedge clk_sys);
        chk(applied, 16'h0000);
        chk(staged, 16'h0000);
        rst_b = 1'b1;
        frame(16'h4800, 16, 1'b0, 3'h4);
        chk(applied, 16'h0000);
        chk(staged, 16'h4800);
        strobe(1'b0);
        chk(applied, 16'h4800);
        complete_run();
    end
endmodule // tb_sdcl_top

`default_nettype wire
